// [dwd_pkg.sv]
`default_nettype none

package dwd_pkg;

  // Serial word layout
  localparam int unsigned WORD_BITS   = 24;
  localparam int unsigned DATA_BITS   = 16;
  localparam int unsigned NUM_CHAN    = 4;
  localparam int unsigned RW_POS      = 23;
  localparam int unsigned DEV_HI_POS  = 22;
  localparam int unsigned DEV_LO_POS  = 21;
  localparam int unsigned REG_HI_POS  = 20;
  localparam int unsigned REG_LO_POS  = 18;
  localparam int unsigned CHAN_HI_POS = 17;
  localparam int unsigned CHAN_LO_POS = 16;
  localparam int unsigned DATA_HI_POS = 15;
  localparam int unsigned DATA_LO_POS = 0;

  // Bit counter
  localparam logic [4:0] BIT_CNT_RST  = 5'h00;
  localparam logic [4:0] BIT_CNT_LAST = 5'h17;
  localparam logic [4:0] BIT_CNT_DONE = 5'h18;

  // Read/write flag values
  localparam logic RW_WRITE = 1'h0;

  // Register select codes
  localparam logic [2:0] SEL_DATA       = 3'h0;
  localparam logic [2:0] SEL_GAIN       = 3'h2;
  localparam logic [2:0] SEL_GAIN_ALL   = 3'h3;
  localparam logic [2:0] SEL_OFFSET     = 3'h4;
  localparam logic [2:0] SEL_OFFSET_ALL = 3'h5;
  localparam logic [2:0] SEL_CLEAR      = 3'h6;
  localparam logic [2:0] SEL_CTRL       = 3'h7;

  // Channel select codes
  localparam logic [1:0] CHAN_A = 2'h0;
  localparam logic [1:0] CHAN_B = 2'h1;
  localparam logic [1:0] CHAN_C = 2'h2;
  localparam logic [1:0] CHAN_D = 2'h3;

  // Reset values
  localparam logic [15:0] OUTPUT_CODE_RST = 16'h0000;
  localparam logic [15:0] GAIN_TRIM_RST   = 16'hFFFF;
  localparam logic [15:0] OFFSET_TRIM_RST = 16'h8000;
  localparam logic [15:0] CLEAR_VALUE_RST = 16'h0000;
  localparam logic [23:0] WORD_RST        = 24'h000000;

  // Synchroniser lanes
  localparam int unsigned SYNC_WIDTH    = 4;
  localparam int unsigned SYNC_TOG_POS  = 3;
  localparam int unsigned SYNC_PIN1_POS = 2;
  localparam int unsigned SYNC_PIN0_POS = 1;
  localparam int unsigned SYNC_CLR_POS  = 0;

endpackage // dwd_pkg

`default_nettype wire

// [dwd_sync.sv]
`default_nettype none

module dwd_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire  logic             clock_i,
  input  wire  logic             nrst_i,
  input  wire  logic [WIDTH-1:0] async_i,
  output var   logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dwd_sync_state_t;

  dwd_sync_state_t state_reg;
  dwd_sync_state_t state_next;

  // Two flops per lane
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = async_i;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stage2;

endmodule // dwd_sync

`default_nettype wire

// [dwd_regs.sv]
// Summary of operation
// [RL1] Select 110 stores data into the addressed clear value; 111 goes to control path.
// [RL2] Channel select 00,01,10,11 picks channel A, B, C, D.
// [RL3] Channel select bits are ignored for broadcast and non-channel operations; select 111 still passes them out on ctrl_channel_o.
// [RL4] Word is 24 bits MSB first: flag, address, select, channel, data.
// [RL5] Select 010 loads data into the gain trim of one channel.
// [RL6] Select 011 loads data into all four gain trims at once.
// [RL7] Gain trims reset to all ones.
// [RL8] Gain trim is straight binary, one LSB per step, full 16 bits.
// [RL9] Select 100 loads data into the offset trim of one channel.
// [RL10] Select 101 loads data into all four offset trims at once.
// [RL11] Offset trim is straight binary, midscale is no change, resets to midscale.
// [RL12] Per channel clear value resets to zero and is loaded on clear.
// [RL13] Only channels with their clear enable set take the clear value.
// [RL14] Host writes with flag zero, device address and 16-bit value.
// [RL15] Top bit selects read or write of the addressed register; there is no read path here, and a word with the top bit set is ignored.
// [RL16] Word acts only when its device address matches the strap pins.
// [RL17] Select 000 loads data into the output code of one channel.
// [RL18] Words for another device address change nothing here.

`default_nettype none

module dwd_regs #(
  parameter int unsigned NUM_CHAN = 4
) (
  input  wire  logic                                   clock_i,
  input  wire  logic                                   nrst_i,
  input  wire  logic                                   link_clk_i,
  input  wire  logic                                   frame_n_i,
  input  wire  logic                                   link_data_i,
  input  wire  logic                                   strap_addr_pin1_i,
  input  wire  logic                                   strap_addr_pin0_i,
  input  wire  logic                                   clear_pin_i,
  input  wire  logic [NUM_CHAN-1:0]                    clear_enable_i,
  output var   logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_output_code_o,
  output var   logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_gain_trim_o,
  output var   logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_offset_trim_o,
  output var   logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_clear_value_o,
  output var   logic                                   ctrl_write_o,
  output var   logic [1:0]                             ctrl_channel_o,
  output var   logic [dwd_pkg::DATA_BITS-1:0]          ctrl_data_o
);

  import dwd_pkg::*;

  // Link side: shifter, cleared by each frame
  typedef struct packed {
    logic [4:0]           bit_cnt;
    logic [WORD_BITS-1:0] shift;
  } dwd_shift_t;

  // Link side: finished word and its event toggle
  typedef struct packed {
    logic [WORD_BITS-1:0] word;
    logic                 word_tog;
  } dwd_hold_t;

  // System side state
  typedef struct packed {
    logic                                  tog_seen;
    logic [NUM_CHAN-1:0][DATA_BITS-1:0]    output_code;
    logic [NUM_CHAN-1:0][DATA_BITS-1:0]    gain_trim;
    logic [NUM_CHAN-1:0][DATA_BITS-1:0]    offset_trim;
    logic [NUM_CHAN-1:0][DATA_BITS-1:0]    clear_value;
    logic                                  ctrl_write;
    logic [1:0]                            ctrl_channel;
    logic [DATA_BITS-1:0]                  ctrl_data;
  } dwd_sys_t;

  dwd_shift_t shift_reg;
  dwd_shift_t shift_next;
  dwd_hold_t  hold_reg;
  dwd_hold_t  hold_next;
  dwd_sys_t   sys_reg;
  dwd_sys_t   sys_next;

  logic                  frame_rst_n;
  logic [SYNC_WIDTH-1:0] sync_in;
  logic [SYNC_WIDTH-1:0] sync_out;
  logic                  tog_s;
  logic [1:0]            strap_s;
  logic                  clear_s;
  logic                  new_word;
  logic                  rw_flag;
  logic [1:0]            dev_addr;
  logic [2:0]            reg_sel;
  logic [1:0]            chan_sel;
  logic [DATA_BITS-1:0]  data_field;
  logic                  accept_write;

  // Shifter held in reset while the frame line is high
  assign frame_rst_n = nrst_i & ~frame_n_i;

  //--------------------------------------------------------------
  // Link clock domain
  //--------------------------------------------------------------

  always_comb begin
    shift_next = shift_reg;
    hold_next  = hold_reg;
    // [RL4] MSB first shift
    if (shift_reg.bit_cnt < BIT_CNT_DONE) begin
      shift_next.shift   = {shift_reg.shift[WORD_BITS-2:0], link_data_i};
      shift_next.bit_cnt = shift_reg.bit_cnt + 5'h01;
    end
    // [RL4] Word complete at bit 24
    if (shift_reg.bit_cnt == BIT_CNT_LAST) begin
      hold_next.word     = {shift_reg.shift[WORD_BITS-2:0], link_data_i};
      hold_next.word_tog = ~hold_reg.word_tog;
    end
  end

  always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_reg.bit_cnt <= BIT_CNT_RST;
      shift_reg.shift   <= WORD_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_reg.word     <= WORD_RST;
      hold_reg.word_tog <= 1'h0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  //--------------------------------------------------------------
  // Crossing into the system clock domain
  //--------------------------------------------------------------

  always_comb begin
    sync_in                = '0;
    sync_in[SYNC_TOG_POS]  = hold_reg.word_tog;
    sync_in[SYNC_PIN1_POS] = strap_addr_pin1_i;
    sync_in[SYNC_PIN0_POS] = strap_addr_pin0_i;
    sync_in[SYNC_CLR_POS]  = clear_pin_i;
  end

  dwd_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (sync_in),
    .sync_o  (sync_out)
  );

  assign tog_s   = sync_out[SYNC_TOG_POS];
  assign strap_s = {sync_out[SYNC_PIN1_POS], sync_out[SYNC_PIN0_POS]};
  assign clear_s = sync_out[SYNC_CLR_POS];

  // Word is stable for a full frame after its toggle
  assign new_word = tog_s ^ sys_reg.tog_seen;

  //--------------------------------------------------------------
  // Field decode
  //--------------------------------------------------------------

  // [RL4] Field split
  assign rw_flag    = hold_reg.word[RW_POS];
  assign dev_addr   = hold_reg.word[DEV_HI_POS:DEV_LO_POS];
  assign reg_sel    = hold_reg.word[REG_HI_POS:REG_LO_POS];
  assign chan_sel   = hold_reg.word[CHAN_HI_POS:CHAN_LO_POS];
  assign data_field = hold_reg.word[DATA_HI_POS:DATA_LO_POS];

  // [RL15] Write flag check
  // [RL16] Strap address match
  // [RL18] Other devices ignored
  assign accept_write = new_word && (rw_flag == RW_WRITE) && (dev_addr == strap_s);

  //--------------------------------------------------------------
  // System clock domain
  //--------------------------------------------------------------

  always_comb begin
    sys_next            = sys_reg;
    sys_next.ctrl_write = 1'h0;
    if (new_word) begin
      sys_next.tog_seen = tog_s;
    end
    if (accept_write) begin
      unique case (reg_sel)
        // [RL2] Channel index from select
        // [RL17] Single output code write
        SEL_DATA: begin
          sys_next.output_code[chan_sel] = data_field;
        end
        // [RL5] Single gain write
        // [RL8] Raw binary code
        SEL_GAIN: begin
          sys_next.gain_trim[chan_sel] = data_field;
        end
        // [RL6] Broadcast gain write
        // [RL3] Channel bits unused
        SEL_GAIN_ALL: begin
          for (int i = 0; i < NUM_CHAN; i++) begin
            sys_next.gain_trim[i] = data_field;
          end
        end
        // [RL9] Single offset write
        // [RL11] Raw binary code
        SEL_OFFSET: begin
          sys_next.offset_trim[chan_sel] = data_field;
        end
        // [RL10] Broadcast offset write
        // [RL3] Channel bits unused
        SEL_OFFSET_ALL: begin
          for (int i = 0; i < NUM_CHAN; i++) begin
            sys_next.offset_trim[i] = data_field;
          end
        end
        // [RL1] Clear value write
        SEL_CLEAR: begin
          sys_next.clear_value[chan_sel] = data_field;
        end
        // [RL1] Control path hand-off
        SEL_CTRL: begin
          sys_next.ctrl_write   = 1'h1;
          sys_next.ctrl_channel = chan_sel;
          sys_next.ctrl_data    = data_field;
        end
        default: begin
          sys_next.ctrl_write = 1'h0;
        end
      endcase
    end
    // [RL12] Clear loads clear value
    // [RL13] Enabled channels only
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (clear_s && clear_enable_i[i]) begin
        sys_next.output_code[i] = sys_reg.clear_value[i];
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_reg.tog_seen <= 1'h0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        sys_reg.output_code[i] <= OUTPUT_CODE_RST;
        // [RL7] Gain reset value
        sys_reg.gain_trim[i]   <= GAIN_TRIM_RST;
        // [RL11] Offset midscale reset
        sys_reg.offset_trim[i] <= OFFSET_TRIM_RST;
        // [RL12] Clear value reset
        sys_reg.clear_value[i] <= CLEAR_VALUE_RST;
      end
      sys_reg.ctrl_write   <= 1'h0;
      sys_reg.ctrl_channel <= CHAN_A;
      sys_reg.ctrl_data    <= OUTPUT_CODE_RST;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // Outputs straight from flops
  assign channel_output_code_o = sys_reg.output_code;
  assign channel_gain_trim_o   = sys_reg.gain_trim;
  assign channel_offset_trim_o = sys_reg.offset_trim;
  assign channel_clear_value_o = sys_reg.clear_value;
  assign ctrl_write_o          = sys_reg.ctrl_write;
  assign ctrl_channel_o        = sys_reg.ctrl_channel;
  assign ctrl_data_o           = sys_reg.ctrl_data;

endmodule // dwd_regs

`default_nettype wire

// [dwd_monitor.sv]
`default_nettype none

module dwd_monitor #(
  parameter int unsigned NUM_CHAN = 4
) (
  input wire logic                                    clock_i,
  input wire logic                                    nrst_i,
  input wire logic                                    frame_n_i,
  input wire logic                                    clear_pin_i,
  input wire logic [NUM_CHAN-1:0]                     clear_enable_i,
  input wire logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_output_code_o,
  input wire logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_gain_trim_o,
  input wire logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_offset_trim_o,
  input wire logic [NUM_CHAN-1:0][dwd_pkg::DATA_BITS-1:0] channel_clear_value_o,
  input wire logic                                    ctrl_write_o,
  input wire logic [1:0]                              ctrl_channel_o,
  input wire logic [dwd_pkg::DATA_BITS-1:0]           ctrl_data_o
);
  import dwd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_clear_held;
    (clear_pin_i && clear_enable_i[0]) [*5];
  endsequence
  sequence s_idle;
    (frame_n_i && !clear_pin_i) [*8];
  endsequence
  property p_clear_force;
    s_clear_held |-> channel_output_code_o[0] == $past(channel_clear_value_o[0]);
  endproperty
  property p_quiet;
    s_idle |-> $stable(channel_output_code_o) && $stable(channel_gain_trim_o) && $stable(channel_offset_trim_o);
  endproperty
  property p_reset_vals;
    $rose(nrst_i) |-> channel_gain_trim_o == {NUM_CHAN{16'hFFFF}} && channel_offset_trim_o == {NUM_CHAN{16'h8000}}
      && channel_clear_value_o == '0;
  endproperty
  property p_gain_bcast;
    $changed(channel_gain_trim_o[0]) && $changed(channel_gain_trim_o[1]) |-> channel_gain_trim_o[0]
      == channel_gain_trim_o[1] && channel_gain_trim_o[2] == channel_gain_trim_o[3];
  endproperty
  property p_offset_bcast;
    $changed(channel_offset_trim_o[0]) && $changed(channel_offset_trim_o[1]) |-> channel_offset_trim_o[0]
      == channel_offset_trim_o[1] && channel_offset_trim_o[2] == channel_offset_trim_o[3];
  endproperty
  property p_ctrl_pulse;
    ctrl_write_o |=> !ctrl_write_o;
  endproperty
  property p_ctrl_hold;
    !ctrl_write_o |-> $stable(ctrl_data_o) && $stable(ctrl_channel_o);
  endproperty
  property p_ctrl_only;
    ctrl_write_o |-> $stable(channel_gain_trim_o) && $stable(channel_offset_trim_o) && $stable(channel_clear_value_o);
  endproperty
  a_clear_force: assert property (p_clear_force) else $error("clear value not forced");
  a_quiet: assert property (p_quiet) else $error("register changed without word");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  a_gain_bcast: assert property (p_gain_bcast) else $error("gain broadcast unequal");
  a_offset_bcast: assert property (p_offset_bcast) else $error("offset broadcast unequal");
  a_ctrl_pulse: assert property (p_ctrl_pulse) else $error("ctrl write too long");
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl fields moved");
  a_ctrl_only: assert property (p_ctrl_only) else $error("ctrl write touched trims");
endmodule // dwd_monitor

bind dwd_regs dwd_monitor #(.NUM_CHAN(NUM_CHAN)) mon (.clock_i(clock_i), .nrst_i(nrst_i), .frame_n_i(frame_n_i),
  .clear_pin_i(clear_pin_i), .clear_enable_i(clear_enable_i), .channel_output_code_o(channel_output_code_o),
  .channel_gain_trim_o(channel_gain_trim_o), .channel_offset_trim_o(channel_offset_trim_o),
  .channel_clear_value_o(channel_clear_value_o), .ctrl_write_o(ctrl_write_o), .ctrl_channel_o(ctrl_channel_o),
  .ctrl_data_o(ctrl_data_o));

`default_nettype wire

// [dwd_host.sv]
`default_nettype none

module dwd_host (
  output var logic link_clk_o,
  output var logic frame_n_o,
  output var logic data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk_o = 1'h0;
    frame_n_o = 1'h1;
    data_o = 1'h0;
  end
  task automatic send(input logic [23:0] w);
    frame_n_o = 1'h0;
    #62.5;
    for (int i = 23; i >= 0; i--) begin
      data_o = w[i];
      #62.5 link_clk_o = 1'h1;
      #62.5 link_clk_o = 1'h0;
    end
    #62.5 frame_n_o = 1'h1;
    data_o = ~data_o;
    #250;
  endtask
endmodule // dwd_host

`default_nettype wire

// [dwd_regs_bench.sv]
`default_nettype none

module dwd_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dwd_pkg::*;
  typedef struct {logic [2:0] sel; logic [1:0] ch; logic [1:0] dev; logic [15:0] data; logic [3:0] mask; logic rw;}
    dwd_row_t;
  logic clock = 1'h0, nrst = 1'h0, link_clk, frame_n, link_data, clear_pin = 1'h0, ctrl_wr;
  logic [1:0]       straps = 2'h2, ctrl_ch;
  logic [3:0]       clear_en = 4'h0;
  logic [15:0]      ctrl_data;
  logic [3:0][15:0] out_code, gain, offs, clrv;
  logic [15:0]      e [4][4];
  int               mismatches = 0, num_checks = 0, cycles = 0;
  int               ctrl_pulses = 0, exp_pulses = 0;
  dwd_row_t rows [12] = '{'{3'h0, 2'h0, 2'h2, 16'h1234, 4'h1, 1'h0}, '{3'h2, 2'h1, 2'h2, 16'h0001, 4'h2, 1'h0},
    '{3'h3, 2'h2, 2'h2, 16'hABCD, 4'hF, 1'h0}, '{3'h4, 2'h3, 2'h2, 16'h0000, 4'h8, 1'h0},
    '{3'h5, 2'h1, 2'h2, 16'hFFFF, 4'hF, 1'h0}, '{3'h6, 2'h2, 2'h2, 16'h5A5A, 4'h4, 1'h0},
    '{3'h6, 2'h0, 2'h2, 16'h0F0F, 4'h1, 1'h0}, '{3'h2, 2'h0, 2'h1, 16'h1111, 4'h0, 1'h0},
    '{3'h2, 2'h0, 2'h2, 16'h2222, 4'h0, 1'h1}, '{3'h1, 2'h0, 2'h2, 16'h3333, 4'h0, 1'h0},
    '{3'h7, 2'h3, 2'h2, 16'h2468, 4'h0, 1'h0}, '{3'h0, 2'h3, 2'h2, 16'hFFFE, 4'h8, 1'h0}};

  dwd_host host (.link_clk_o(link_clk), .frame_n_o(frame_n), .data_o(link_data));
  dwd_regs #(.NUM_CHAN(4)) dut (.clock_i(clock), .nrst_i(nrst), .link_clk_i(link_clk), .frame_n_i(frame_n),
    .link_data_i(link_data), .strap_addr_pin1_i(straps[1]), .strap_addr_pin0_i(straps[0]), .clear_pin_i(clear_pin),
    .clear_enable_i(clear_en), .channel_output_code_o(out_code), .channel_gain_trim_o(gain),
    .channel_offset_trim_o(offs), .channel_clear_value_o(clrv), .ctrl_write_o(ctrl_wr), .ctrl_channel_o(ctrl_ch),
    .ctrl_data_o(ctrl_data));

  always #12.5 clock = ~clock;

  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Count control write pulses where they are settled
  always @(negedge clock) begin
    if (ctrl_wr === 1'h1) begin
      ctrl_pulses++;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_all();
    for (int c = 0; c < 4; c++) begin
      check(out_code[c], e[0][c]);
      check(gain[c], e[1][c]);
      check(offs[c], e[2][c]);
      check(clrv[c], e[3][c]);
    end
  endtask

  task automatic do_reset();
    nrst <= 1'h0;
    repeat (6) @(posedge clock);
    nrst <= 1'h1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    for (int c = 0; c < 4; c++) begin
      e[0][c] = 16'h0000;
      e[1][c] = 16'hFFFF;
      e[2][c] = 16'h8000;
      e[3][c] = 16'h0000;
    end
  endtask

  function automatic int kind(logic [2:0] s);
    return s == 3'h6 ? 3 : s[2] ? 2 : s[1] ? 1 : 0;
  endfunction

  initial begin
    do_reset();
    check_all();
    foreach (rows[i]) begin
      host.send({rows[i].rw, rows[i].dev, rows[i].sel, rows[i].ch, rows[i].data});
      @(negedge clock);
      for (int c = 0; c < 4; c++)
        if (rows[i].mask[c])
          e[kind(rows[i].sel)][c] = rows[i].data;
      if (rows[i].sel == SEL_CTRL) begin
        exp_pulses++;
        check(ctrl_data, rows[i].data);
        check({14'h0, ctrl_ch}, {14'h0, rows[i].ch});
      end
      check_all();
      check(16'(ctrl_pulses), 16'(exp_pulses));
    end
    @(posedge clock);
    clear_en <= 4'h5;
    clear_pin <= 1'h1;
    repeat (8) @(posedge clock);
    @(negedge clock);
    e[0][0] = e[3][0];
    e[0][2] = e[3][2];
    check_all();
    @(posedge clock);
    clear_pin <= 1'h0;
    repeat (5) @(posedge clock);
    do_reset();
    check_all();
    finish_test();
  end
endmodule // dwd_regs_bench

`default_nettype wire
